/* File: core/ttgc_pkg.sv */
package ttgc_pkg;

   // ---------------------------------------------------------
   // Register map: address = {timer[1:0], register[2:0]}
   // ---------------------------------------------------------
   localparam int NTMR = 3;
   localparam logic [1:0] TMR_NONE = 2'h3;
   localparam logic [2:0] REG_CFG = 3'h0;
   localparam logic [2:0] REG_CNTH = 3'h1;
   localparam logic [2:0] REG_CNTL = 3'h2;
   localparam logic [2:0] REG_PRDH = 3'h3;
   localparam logic [2:0] REG_PRDL = 3'h4;
   localparam logic [2:0] REG_WIDH = 3'h5;
   localparam logic [2:0] REG_WIDL = 3'h6;
   localparam logic [2:0] REG_GSR = 3'h7;

   // ---------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_PULSE_HI = 2;
   localparam int CFG_PERIOD_CNT = 3;
   localparam int CFG_IRQ_ENA = 4;
   localparam int CFG_IN_SEL = 5;
   localparam int GSR_IL_LSB = 0;
   localparam int GSR_OVF_LSB = 4;
   localparam int GSR_EN_LSB = 8;

   // ---------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [1:0] START_DLY = 2'h3;
   localparam logic [31:0] CNT_ALL = 32'hffff_ffff;
   localparam logic [31:0] CNT_TOP = 32'hffff_fffe;

   // Operating mode field encodings
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_PWM = 2'b01,
      MODE_CAPTURE = 2'b10,
      MODE_EVENT = 2'b11
   } ttgc_mode_e;

endpackage : ttgc_pkg

/* File: core/ttgc_sync.sv */
`timescale 1ns/1ps

module ttgc_sync
   import ttgc_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic [3:0] async_in, // Pins and receive line
   output logic [3:0] sync_out // Synchronised levels
);

   // ---------------------------------------------------------
   // State
   // ---------------------------------------------------------
   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] stab;
   } ttgc_sync_s;

   ttgc_sync_s s_q;
   ttgc_sync_s s_d;

   // Two-stage capture; only the second stage is read
   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.stab = s_q.meta;
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stab;

endmodule : ttgc_sync

/* File: core/ttgc_top.sv */
// Contract
// - Three identical timers, three selectable modes
// - Pin drives in PWM, input otherwise
// - Eight 16-bit registers, six paired
// - Count halves form one 32-bit counter
// - Every global register shows all timers
// - Write-one enable/disable; both means disable
// - Enabled reads both ones; count after three
// - Disable halts the timer at once
// - Sticky latch and overflow, write-one clear
// - One write clears flags and enables
// - Interrupt-enable clear never sets latch
// - Latch sets even when core masks
// - Capture may use UART receive line
// - Captured period split over two halves
// - 0x0100 enables, 0x0001 clears latch
// - 0x0200 disables; period stays readable
// - Latches 0-2, errors 4-6, enables 8-13
// - Mode 01 selects PWM, pin driven
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

module ttgc_top
   import ttgc_pkg::*;
(
   input wire logic ref_clk, // 50 MHz clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic [4:0] reg_addr, // Register address
   input wire logic [15:0] reg_wdata, // Write data
   input wire logic reg_we, // Write strobe
   input wire logic reg_re, // Read strobe
   output logic [15:0] reg_rdata, // Read data, cycle after strobe
   input wire logic [2:0] timer_pin_in, // Timer pin level in
   output logic [2:0] timer_pin_out, // Timer pin level out
   output logic [2:0] timer_pin_oe_b, // Pin drive enable, low drives
   input wire logic uart_rx // UART receive line
);

   // ---------------------------------------------------------
   // State
   // ---------------------------------------------------------
   typedef struct packed {
      logic [2:0][15:0] cfg;
      logic [2:0][31:0] shd_prd;
      logic [2:0][15:0] shd_wh;
      logic [2:0][31:0] prd;
      logic [2:0][31:0] wid;
      logic [2:0][31:0] cnt;
      logic [2:0][1:0] dly;
      logic [2:0] run;
      logic [2:0] act;
      logic [2:0] phase;
      logic [2:0] armed;
      logic [2:0] lvl;
      logic [2:0] il;
      logic [2:0] ovf;
      logic [2:0] pin;
      logic [15:0] rdata;
   } ttgc_state_s;

   ttgc_state_s s_q;
   ttgc_state_s s_d;

   logic [3:0] sync_lvl;
   logic [2:0] in_lvl;
   logic [2:0] lead;
   logic [2:0] trail;
   logic [15:0] gsr_view;
   logic [1:0] tsel;
   logic [2:0] rsel;
   logic gsr_wr;
   logic [2:0] set_il;
   logic [2:0] set_ovf;
   logic [2:0] clr_il;
   logic [2:0] clr_ovf;
   logic [2:0] en_wr;
   logic [2:0] dis_wr;

   // ---------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------

   // Timer pins and the UART receive line cross in here
   ttgc_sync u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in({uart_rx, timer_pin_in}),
      .sync_out(sync_lvl)
   );

   // ---------------------------------------------------------
   // Input selection and edge detection
   // ---------------------------------------------------------

   // Capture input from own pin or from the receive line
   for (genvar g = 0; g < NTMR; g++) begin : g_in
      assign in_lvl[g] = s_q.cfg[g][CFG_IN_SEL] ? sync_lvl[3] : sync_lvl[g];
      assign lead[g] = s_q.cfg[g][CFG_PULSE_HI] ? (in_lvl[g] & ~s_q.lvl[g])
                                                : (~in_lvl[g] & s_q.lvl[g]);
      assign trail[g] = s_q.cfg[g][CFG_PULSE_HI] ? (~in_lvl[g] & s_q.lvl[g])
                                                 : (in_lvl[g] & ~s_q.lvl[g]);
      assign clr_il[g] = gsr_wr & reg_wdata[GSR_IL_LSB + g];
      assign clr_ovf[g] = gsr_wr & reg_wdata[GSR_OVF_LSB + g];
      assign en_wr[g] = gsr_wr & reg_wdata[GSR_EN_LSB + 2 * g];
      assign dis_wr[g] = gsr_wr & reg_wdata[GSR_EN_LSB + 2 * g + 1];
      assign gsr_view[GSR_IL_LSB + g] = s_q.il[g];
      assign gsr_view[GSR_OVF_LSB + g] = s_q.ovf[g];
      assign gsr_view[GSR_EN_LSB + 2 * g] = s_q.run[g];
      assign gsr_view[GSR_EN_LSB + 2 * g + 1] = s_q.run[g];
      assign timer_pin_oe_b[g] = (s_q.cfg[g][1:0] != MODE_PWM);
   end

   // Reserved global bits are constant zero
   assign gsr_view[3] = 1'b0;
   assign gsr_view[7] = 1'b0;
   assign gsr_view[15:14] = 2'h0;

   // Bus decode; the fourth timer slot is unmapped
   assign tsel = reg_addr[4:3];
   assign rsel = reg_addr[2:0];
   assign gsr_wr = reg_we && (tsel != TMR_NONE) && (rsel == REG_GSR);

   // ---------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------
   always_comb begin
      s_d = s_q;
      set_il = 3'h0;
      set_ovf = 3'h0;
      for (int i = 0; i < NTMR; i++) begin
         s_d.lvl[i] = in_lvl[i];

         // Start sequence: counting begins on the third edge
         if (s_q.run[i] && (s_q.dly[i] != 2'h0)) begin
            s_d.dly[i] = s_q.dly[i] - 2'h1;
            if (s_q.dly[i] == 2'h1) begin
               unique case (ttgc_mode_e'(s_q.cfg[i][1:0]))
                  MODE_PWM: begin
                     if ((s_q.wid[i] == 32'h0) || (s_q.prd[i] <= s_q.wid[i])) begin
                        set_ovf[i] = 1'b1;
                        set_il[i] = 1'b1;
                     end else begin
                        s_d.act[i] = 1'b1;
                        s_d.phase[i] = 1'b1;
                        s_d.cnt[i] = CNT_ALL - s_q.wid[i];
                     end
                  end
                  MODE_CAPTURE, MODE_EVENT: begin
                     s_d.act[i] = 1'b1;
                     s_d.armed[i] = 1'b0;
                     s_d.cnt[i] = 32'h0;
                  end
                  MODE_OFF: begin
                     s_d.act[i] = 1'b0;
                  end
               endcase
            end
         end else if (s_q.act[i]) begin
            // Running behaviour per mode
            unique case (ttgc_mode_e'(s_q.cfg[i][1:0]))
               MODE_PWM: begin
                  if (s_q.cnt[i] == CNT_TOP) begin
                     if (s_q.phase[i]) begin
                        s_d.phase[i] = 1'b0;
                        s_d.cnt[i] = CNT_ALL - (s_q.prd[i] - s_q.wid[i]);
                        if (!s_q.cfg[i][CFG_PERIOD_CNT]) begin
                           s_d.act[i] = 1'b0;
                           s_d.run[i] = 1'b0;
                           set_il[i] = 1'b1;
                        end
                     end else begin
                        s_d.phase[i] = 1'b1;
                        s_d.cnt[i] = CNT_ALL - s_q.wid[i];
                        set_il[i] = 1'b1;
                     end
                  end else begin
                     s_d.cnt[i] = s_q.cnt[i] + 32'h1;
                  end
               end
               MODE_CAPTURE: begin
                  s_d.cnt[i] = s_q.cnt[i] + 32'h1;
                  if (s_q.cnt[i] == CNT_ALL) begin
                     set_ovf[i] = 1'b1;
                  end
                  if (lead[i]) begin
                     if (s_q.armed[i]) begin
                        s_d.prd[i] = s_q.cnt[i];
                        set_il[i] = s_q.cfg[i][CFG_PERIOD_CNT];
                     end
                     s_d.armed[i] = 1'b1;
                     s_d.cnt[i] = 32'h1;
                  end
                  if (trail[i] && s_q.armed[i]) begin
                     s_d.wid[i] = s_q.cnt[i];
                     set_il[i] = !s_q.cfg[i][CFG_PERIOD_CNT];
                  end
               end
               MODE_EVENT: begin
                  if (in_lvl[i] && !s_q.lvl[i]) begin
                     if (s_q.cnt[i] + 32'h1 == s_q.prd[i]) begin
                        s_d.cnt[i] = 32'h0;
                        set_il[i] = 1'b1;
                     end else begin
                        s_d.cnt[i] = s_q.cnt[i] + 32'h1;
                        set_ovf[i] = (s_q.cnt[i] == CNT_ALL);
                     end
                  end
               end
               MODE_OFF: begin
                  s_d.act[i] = 1'b0;
               end
            endcase
         end

         // Enable and disable; disable wins and acts at once
         if (dis_wr[i]) begin
            s_d.run[i] = 1'b0;
            s_d.act[i] = 1'b0;
            s_d.dly[i] = 2'h0;
         end else if (en_wr[i] && !s_q.run[i]) begin
            s_d.run[i] = 1'b1;
            s_d.dly[i] = START_DLY - 2'h1;
         end

         // Sticky flags; a set in the clearing cycle wins
         s_d.il[i] = (s_q.il[i] & ~clr_il[i]) | (set_il[i] & s_q.cfg[i][CFG_IRQ_ENA]);
         s_d.ovf[i] = (s_q.ovf[i] & ~clr_ovf[i]) | set_ovf[i];

         // PWM pin low unless running
         s_d.pin[i] = s_d.act[i] && (s_q.cfg[i][1:0] == MODE_PWM)
                      && (s_d.phase[i] == s_q.cfg[i][CFG_PULSE_HI]);
      end

      // Register writes; width low commits the shadows
      if (reg_we && (tsel != TMR_NONE)) begin
         unique case (rsel)
            REG_CFG: s_d.cfg[tsel] = reg_wdata;
            REG_PRDH: s_d.shd_prd[tsel][31:16] = reg_wdata;
            REG_PRDL: s_d.shd_prd[tsel][15:0] = reg_wdata;
            REG_WIDH: s_d.shd_wh[tsel] = reg_wdata;
            REG_WIDL: begin
               s_d.prd[tsel] = s_q.shd_prd[tsel];
               s_d.wid[tsel] = {s_q.shd_wh[tsel], reg_wdata};
            end
            REG_CNTH, REG_CNTL, REG_GSR: begin
               s_d.rdata = s_d.rdata;
            end
         endcase
      end

      // Read data for one cycle only
      s_d.rdata = REG_RST;
      if (reg_re && (tsel != TMR_NONE)) begin
         unique case (rsel)
            REG_CFG: s_d.rdata = s_q.cfg[tsel];
            REG_CNTH: s_d.rdata = s_q.cnt[tsel][31:16];
            REG_CNTL: s_d.rdata = s_q.cnt[tsel][15:0];
            REG_PRDH: s_d.rdata = s_q.prd[tsel][31:16];
            REG_PRDL: s_d.rdata = s_q.prd[tsel][15:0];
            REG_WIDH: s_d.rdata = s_q.wid[tsel][31:16];
            REG_WIDL: s_d.rdata = s_q.wid[tsel][15:0];
            REG_GSR: s_d.rdata = gsr_view;
         endcase
      end
   end

   // ---------------------------------------------------------
   // State register
   // ---------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign timer_pin_out = s_q.pin;

   // ---------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------
   logic wr_gsr0;
   assign wr_gsr0 = reg_we && (reg_addr == {2'h0, REG_GSR});

   sequence s_wait_start;
      (!s_q.act[0]) [*2] ##1 (s_q.act[0] || s_q.ovf[0] || !s_q.run[0]);
   endsequence

   property p_enable;
      @(posedge ref_clk) disable iff (!rst_b)
      wr_gsr0 && reg_wdata[8] && !reg_wdata[9] |=> s_q.run[0] && gsr_view[9:8] == 2'h3;
   endproperty
   a_enable: assert property (p_enable) else $error("enable did not start timer");

   property p_both_disable;
      @(posedge ref_clk) disable iff (!rst_b)
      wr_gsr0 && reg_wdata[8] && reg_wdata[9] |=> !s_q.run[0];
   endproperty
   a_both_disable: assert property (p_both_disable) else $error("both bits did not disable");

   property p_halt;
      @(posedge ref_clk) disable iff (!rst_b)
      wr_gsr0 && reg_wdata[9] |=> !s_q.act[0] ##1 (s_q.cnt[0] == $past(s_q.cnt[0]));
   endproperty
   a_halt: assert property (p_halt) else $error("disable did not halt counter");

   property p_start_delay;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(s_q.run[0]) |-> s_wait_start;
   endproperty
   a_start_delay: assert property (p_start_delay) else $error("start delay not three cycles");

   property p_no_latch;
      @(posedge ref_clk) disable iff (!rst_b)
      !s_q.cfg[0][CFG_IRQ_ENA] && !s_q.il[0] |=> !s_q.il[0];
   endproperty
   a_no_latch: assert property (p_no_latch) else $error("latch set with interrupts off");

   property p_sticky;
      @(posedge ref_clk) disable iff (!rst_b)
      s_q.il[0] && !(wr_gsr0 && reg_wdata[0]) |=> s_q.il[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("latch dropped without clear");

   property p_reserved;
      @(posedge ref_clk) disable iff (!rst_b)
      reg_re && reg_addr == {2'h1, REG_GSR} |=> reg_rdata[3] == 1'b0 && reg_rdata[7] == 1'b0
         && reg_rdata[15:14] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_pwm_drive;
      @(posedge ref_clk) disable iff (!rst_b)
      s_q.cfg[1][1:0] == MODE_PWM |-> !timer_pin_oe_b[1] && (s_q.act[1] || !timer_pin_out[1]);
   endproperty
   a_pwm_drive: assert property (p_pwm_drive) else $error("pwm pin not driven");

   property p_global_view;
      @(posedge ref_clk) disable iff (!rst_b)
      reg_re && reg_addr == {2'h2, REG_GSR} |=> reg_rdata[2:0] == $past(s_q.il);
   endproperty
   a_global_view: assert property (p_global_view) else $error("global view mismatch");

endmodule : ttgc_top

/* File: verif/ttgc_far_end.sv */
`timescale 1ns/1ps

module ttgc_far_end (
   input wire logic ref_clk, // System clock
   output logic [2:0] ext_pin, // Levels driven onto timer pins
   output logic rx_line // UART receive line
);
   // Lines rest high, as with a pull-up
   initial begin
      ext_pin = 3'h7;
      rx_line = 1'b1;
   end

   // Low-then-high pulses, falling edges gap cycles apart; ch 3 is the receive line
   task automatic pulses(input int ch, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         if (ch == 3) rx_line <= 1'b0;
         else ext_pin[ch] <= 1'b0;
         repeat (gap / 2) @(posedge ref_clk);
         if (ch == 3) rx_line <= 1'b1;
         else ext_pin[ch] <= 1'b1; // Rising edge is the counted event
         repeat (gap - gap / 2 - 1) @(posedge ref_clk);
      end
   endtask : pulses
endmodule : ttgc_far_end

/* File: verif/ttgc_tb_top.sv */
`timescale 1ns/1ps

module ttgc_tb_top
   import ttgc_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [15:0] reg_rdata;
   logic [2:0] timer_pin_out;
   logic [2:0] timer_pin_oe_b;
   logic [2:0] timer_pin_in;
   logic [2:0] ext_pin;
   logic uart_rx;
   logic rd_pend = 1'b0;
   logic [15:0] exp_q[$];
   logic [15:0] msk_q[$];
   logic [15:0] v;
   int failures = 0;
   int check_count = 0;
   int gap;
   int hits;

   // ---------------------------------------------
   // Clock, pin resolution and instances
   // ---------------------------------------------
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // A pin shows the design's level while it drives, else the far end's
   assign timer_pin_in = (ext_pin & timer_pin_oe_b) | (timer_pin_out & ~timer_pin_oe_b);

   ttgc_top u_ttgc_top (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_we(reg_we),
      .reg_re(reg_re),
      .reg_rdata(reg_rdata),
      .timer_pin_in(timer_pin_in),
      .timer_pin_out(timer_pin_out),
      .timer_pin_oe_b(timer_pin_oe_b),
      .uart_rx(uart_rx)
   );

   ttgc_far_end u_ttgc_far_end (
      .ref_clk(ref_clk),
      .ext_pin(ext_pin),
      .rx_line(uart_rx)
   );

   // ---------------------------------------------
   // Bus tasks and comparison
   // ---------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : check

   task automatic report_and_stop();
      if (failures == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask : wr

   // Notes the expected value and mask, then issues a one-cycle read
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m,
                     output logic [15:0] d);
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge ref_clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Bounded wait for a status bit
   task automatic poll(input logic [4:0] a, input logic [15:0] bitm);
      logic [15:0] d;
      for (int i = 0; i < 300; i++) begin
         rd(a, 16'h0000, 16'h0000, d);
         if ((d & bitm) != 16'h0000) return;
      end
      failures++;
      report_and_stop();
   endtask : poll

   // Read data stand in the cycle after the strobe; compare with the oldest note
   always @(posedge ref_clk) begin
      rd_pend <= reg_re;
      if (rd_pend) begin
         check("read data", exp_q[0] & msk_q[0], reg_rdata & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      void'($urandom(7));
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1 check("pin enables", 16'h0007, {13'h0, timer_pin_oe_b});
      // Reserved bits, read-only count, unmapped slot
      wr({2'h0, REG_GSR}, 16'hc088);
      wr({2'h0, REG_CNTH}, 16'h1234);
      wr({TMR_NONE, REG_CFG}, 16'h0001);
      rd({2'h0, REG_GSR}, 16'h0000, 16'hffff, v);
      rd({2'h0, REG_CNTH}, 16'h0000, 16'hffff, v);
      rd({TMR_NONE, REG_CFG}, 16'h0000, 16'hffff, v);
      // Valid repeating PWM on timer 0, period 10, width 4
      wr({2'h0, REG_CFG}, 16'h000d);
      wr({2'h0, REG_PRDH}, 16'h0000);
      wr({2'h0, REG_PRDL}, 16'h000a);
      wr({2'h0, REG_WIDH}, 16'h0000);
      wr({2'h0, REG_WIDL}, 16'h0004);
      rd({2'h0, REG_CFG}, 16'h000d, 16'hffff, v);
      rd({2'h0, REG_PRDL}, 16'h000a, 16'hffff, v);
      check("pin enables", 16'h0006, {13'h0, timer_pin_oe_b});
      wr({2'h0, REG_GSR}, 16'h0100);
      rd({2'h1, REG_GSR}, 16'h0300, 16'hffff, v);
      rd({2'h0, REG_CNTH}, 16'hffff, 16'hffff, v);
      hits = 0;
      repeat (10) begin
         @(posedge ref_clk);
         hits += timer_pin_out[0];
      end
      check("pwm high cycles", 16'h0004, hits[15:0]);
      wr({2'h0, REG_GSR}, 16'h0200);
      @(posedge ref_clk);
      #1 check("pin 0 level", 16'h0000, {15'h0, timer_pin_out[0]});
      rd({2'h2, REG_GSR}, 16'h0000, 16'hffff, v);
      wr({2'h0, REG_GSR}, 16'h0100);
      wr({2'h0, REG_GSR}, 16'h0300);
      rd({2'h0, REG_GSR}, 16'h0000, 16'h0300, v);
      // Implausible PWM on timer 1, latch off then on
      wr({2'h1, REG_CFG}, 16'h0001);
      wr({2'h1, REG_GSR}, 16'h0400);
      // Plausibility flags appear only after the start delay
      repeat (2) @(posedge ref_clk);
      rd({2'h1, REG_GSR}, 16'h0020, 16'h0077, v);
      wr({2'h1, REG_GSR}, 16'h0820);
      rd({2'h1, REG_GSR}, 16'h0000, 16'h0c77, v);
      wr({2'h1, REG_CFG}, 16'h0011);
      wr({2'h1, REG_GSR}, 16'h0400);
      repeat (2) @(posedge ref_clk);
      rd({2'h1, REG_GSR}, 16'h0022, 16'h0077, v);
      rd({2'h0, REG_GSR}, 16'h0022, 16'h0077, v);
      wr({2'h1, REG_GSR}, 16'h0822);
      rd({2'h1, REG_GSR}, 16'h0000, 16'h0c77, v);
      // Period capture of timer 0 from the receive line
      gap = 16 + ($urandom % 64);
      wr({2'h0, REG_CFG}, 16'h003a);
      wr({2'h0, REG_GSR}, 16'h0101);
      repeat (4) @(posedge ref_clk);
      u_ttgc_far_end.pulses(3, 3, gap);
      poll({2'h0, REG_GSR}, 16'h0001);
      wr({2'h0, REG_GSR}, 16'h0200);
      rd({2'h0, REG_PRDH}, 16'h0000, 16'hffff, v);
      rd({2'h0, REG_PRDL}, gap[15:0], 16'hffff, v);
      // Event counting on timer 2
      hits = 2 + ($urandom % 5);
      wr({2'h2, REG_CFG}, 16'h0013);
      wr({2'h2, REG_PRDL}, hits[15:0]);
      wr({2'h2, REG_WIDL}, 16'h0001);
      wr({2'h2, REG_GSR}, 16'h1000);
      rd({2'h0, REG_GSR}, 16'h3000, 16'h3004, v);
      repeat (4) @(posedge ref_clk);
      u_ttgc_far_end.pulses(2, hits - 1, 8);
      repeat (8) @(posedge ref_clk);
      rd({2'h2, REG_GSR}, 16'h0000, 16'h0004, v);
      u_ttgc_far_end.pulses(2, 1, 8);
      poll({2'h2, REG_GSR}, 16'h0004);
      wr({2'h2, REG_GSR}, 16'h2004);
      rd({2'h2, REG_GSR}, 16'h0000, 16'h3004, v);
      repeat (4) @(posedge ref_clk);
      report_and_stop();
   end
endmodule : ttgc_tb_top
